// File: verilog/vwm_monitor.sv
// Functional notes
// - Target-reached bit set while actual velocity lies inside window around target.
// - Zero-speed bit set when actual velocity magnitude is at or below threshold.
// - Both comparisons act at once, no dwell or qualification delay.
// - Comparisons only drive the status bits in velocity modes.
// - Sensor velocity is per-sample increments times rate, negated by polarity bit.
// - Actual velocity is sensor velocity scaled into velocity units, signed 32-bit.
// - Velocity demand readable, signed 32-bit, from the demand generator output.
// - Window and threshold are unsigned 16-bit read/write, reset to zero.
// - Tuning record groups eight sub-entries: divider, position and velocity gains/errors.
// - Rate divider is signed 16-bit read/write, default one, minimum one.
// - P gains default 0.05, I gains 2.0, velocity integral-error gain 0.0.
// - Position and velocity loop errors are read-only, per sample, cyclically mappable.
`timescale 1ns/100ps
`default_nettype none
module vwm_monitor #(
    parameter logic [31:0] SAMPLE_RATE_HZ = vwm_pkg::SAMPLE_RATE_HZ_DEF
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sample_tick,
    input wire logic velocity_mode,
    input wire logic velocity_polarity,
    input wire logic [31:0] vel_incs_per_sample,
    input wire logic [31:0] target_velocity,
    input wire logic [31:0] demand_velocity,
    input wire logic [31:0] vel_unit_scale,
    input wire logic [31:0] posmode_error_in,
    input wire logic [31:0] velmode_error_in,
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_subindex,
    input wire logic [31:0] od_wdata,
    output logic od_ack,
    output logic od_abort,
    output logic [31:0] od_abort_code,
    output logic [31:0] od_rdata,
    output logic target_reached,
    output logic zero_speed,
    output logic [31:0] sensor_velocity,
    output logic [31:0] velocity_actual,
    output logic [31:0] velocity_demand,
    output logic [15:0] loop_rate_divider,
    output logic [31:0] posmode_p_gain,
    output logic [31:0] posmode_i_gain,
    output logic [31:0] velmode_p_gain,
    output logic [31:0] velmode_i_gain,
    output logic [31:0] velmode_integral_error_gain,
    output logic [31:0] posmode_loop_error,
    output logic [31:0] velmode_loop_error
);

    typedef struct packed {
        logic [31:0] sensor_velocity;
        logic [31:0] velocity_demand;
        logic [31:0] velocity_actual;
        logic [15:0] velocity_window;
        logic [15:0] velocity_threshold;
        logic [15:0] loop_rate_divider;
        logic [31:0] posmode_p_gain;
        logic [31:0] posmode_i_gain;
        logic [31:0] posmode_loop_error;
        logic [31:0] velmode_p_gain;
        logic [31:0] velmode_i_gain;
        logic [31:0] velmode_integral_error_gain;
        logic [31:0] velmode_loop_error;
        logic target_reached;
        logic zero_speed;
        logic ack;
        logic abort;
        logic [31:0] abort_code;
        logic [31:0] rdata;
    } vwm_state_t;

    localparam vwm_state_t RESET_STATE = '{
        sensor_velocity: vwm_pkg::RST_VALUE32,
        velocity_demand: vwm_pkg::RST_VALUE32,
        velocity_actual: vwm_pkg::RST_VALUE32,
        velocity_window: vwm_pkg::RST_VALUE16,
        velocity_threshold: vwm_pkg::RST_VALUE16,
        loop_rate_divider: vwm_pkg::RST_RATE_DIVIDER,
        posmode_p_gain: vwm_pkg::RST_P_GAIN,
        posmode_i_gain: vwm_pkg::RST_I_GAIN,
        posmode_loop_error: vwm_pkg::RST_VALUE32,
        velmode_p_gain: vwm_pkg::RST_P_GAIN,
        velmode_i_gain: vwm_pkg::RST_I_GAIN,
        velmode_integral_error_gain: vwm_pkg::RST_INTEGRAL_ERROR_GAIN,
        velmode_loop_error: vwm_pkg::RST_VALUE32,
        target_reached: 1'b0,
        zero_speed: 1'b0,
        ack: 1'b0,
        abort: 1'b0,
        abort_code: vwm_pkg::ABORT_NONE,
        rdata: vwm_pkg::RST_VALUE32
    };

    vwm_state_t state;
    vwm_state_t next_state;

    logic [31:0] incs_per_sec;
    logic [31:0] next_sensor;
    logic [31:0] next_actual;
    logic [32:0] window_delta;
    logic [32:0] speed_magnitude;
    logic in_window;
    logic below_threshold;
    logic [31:0] read_value;
    logic [31:0] access_abort;
    logic read_only;

    // Magnitude of a signed 33-bit value, never overflows
    function automatic logic [32:0] vwm_abs33(input logic [32:0] value);
        vwm_abs33 = value[32] ? (~value + 33'h1) : value;
    endfunction

    // Float gains accept no negative value
    function automatic logic vwm_negative_float(input logic [31:0] value);
        vwm_negative_float = value[vwm_pkg::FLOAT_SIGN_BIT];
    endfunction

    // Per-sample increments into increments per second, polarity applied
    always_comb begin
        incs_per_sec = vel_incs_per_sample * SAMPLE_RATE_HZ;
        next_sensor = velocity_polarity ? (~incs_per_sec + 32'h1) : incs_per_sec;
    end

    // Sensor value into velocity units
    vwm_vel_scaler #(
        .FRAC_BITS(vwm_pkg::SCALE_FRAC_BITS)
    ) u_scaler (
        .sensor_velocity(next_sensor),
        .unit_scale(vel_unit_scale),
        .scaled_velocity(next_actual)
    );

    // Window and threshold tests on the fresh sample
    always_comb begin
        window_delta = {next_actual[31], next_actual}
                       - {target_velocity[31], target_velocity};
        in_window = vwm_abs33(window_delta)
                    <= {17'h0, state.velocity_window};
        speed_magnitude = vwm_abs33({next_actual[31], next_actual});
        below_threshold = speed_magnitude
                          <= {17'h0, state.velocity_threshold};
    end

    // Object decode: read value, abort code and write protection
    always_comb begin
        read_value = vwm_pkg::RST_VALUE32;
        access_abort = vwm_pkg::ABORT_NONE;
        read_only = 1'b1;
        unique case (od_index)
            vwm_pkg::IDX_SENSOR_VELOCITY: read_value = state.sensor_velocity;
            vwm_pkg::IDX_VELOCITY_DEMAND: read_value = state.velocity_demand;
            vwm_pkg::IDX_VELOCITY_ACTUAL: read_value = state.velocity_actual;
            vwm_pkg::IDX_VELOCITY_WINDOW: begin
                read_value = {16'h0, state.velocity_window};
                read_only = 1'b0;
            end
            vwm_pkg::IDX_VELOCITY_THRESHOLD: begin
                read_value = {16'h0, state.velocity_threshold};
                read_only = 1'b0;
            end
            vwm_pkg::IDX_VELOCITY_LOOP_SET: begin
                read_only = 1'b0;
                unique case (od_subindex)
                    vwm_pkg::SUB_ZERO: begin
                        read_value = {24'h0, vwm_pkg::RECORD_ENTRIES};
                        read_only = 1'b1;
                    end
                    vwm_pkg::SUB_RATE_DIVIDER: begin
                        read_value = {{16{state.loop_rate_divider[15]}},
                                      state.loop_rate_divider};
                    end
                    vwm_pkg::SUB_POSMODE_P_GAIN: read_value = state.posmode_p_gain;
                    vwm_pkg::SUB_POSMODE_I_GAIN: read_value = state.posmode_i_gain;
                    vwm_pkg::SUB_POSMODE_LOOP_ERROR: begin
                        read_value = state.posmode_loop_error;
                        read_only = 1'b1;
                    end
                    vwm_pkg::SUB_VELMODE_P_GAIN: read_value = state.velmode_p_gain;
                    vwm_pkg::SUB_VELMODE_I_GAIN: read_value = state.velmode_i_gain;
                    vwm_pkg::SUB_VELMODE_INTEGRAL_ERROR_GAIN: begin
                        read_value = state.velmode_integral_error_gain;
                    end
                    vwm_pkg::SUB_VELMODE_LOOP_ERROR: begin
                        read_value = state.velmode_loop_error;
                        read_only = 1'b1;
                    end
                    default: begin
                        access_abort = vwm_pkg::ABORT_NO_SUBINDEX;
                        read_only = 1'b1;
                    end
                endcase
            end
            default: access_abort = vwm_pkg::ABORT_NO_OBJECT;
        endcase
        // Plain objects have only sub-index zero
        if (access_abort == vwm_pkg::ABORT_NONE
            && od_index != vwm_pkg::IDX_VELOCITY_LOOP_SET
            && od_subindex != vwm_pkg::SUB_ZERO) begin
            access_abort = vwm_pkg::ABORT_NO_SUBINDEX;
        end
        // Writes to read-only entries are refused
        if (access_abort == vwm_pkg::ABORT_NONE && od_write && read_only) begin
            access_abort = vwm_pkg::ABORT_READ_ONLY;
        end
        // Range checks on accepted writes
        if (access_abort == vwm_pkg::ABORT_NONE && od_write
            && od_index == vwm_pkg::IDX_VELOCITY_LOOP_SET) begin
            if (od_subindex == vwm_pkg::SUB_RATE_DIVIDER
                && $signed(od_wdata[15:0]) < $signed(vwm_pkg::MIN_RATE_DIVIDER)) begin
                access_abort = vwm_pkg::ABORT_VALUE_LOW;
            end else if (od_subindex != vwm_pkg::SUB_RATE_DIVIDER
                         && vwm_negative_float(od_wdata)) begin
                access_abort = vwm_pkg::ABORT_VALUE_LOW;
            end
        end
    end

    // Next state: sampling, status bits and object access
    always_comb begin
        next_state = state;
        next_state.ack = 1'b0;
        // Refresh all sampled values once per sample period
        if (sample_tick) begin
            next_state.sensor_velocity = next_sensor;
            next_state.velocity_actual = next_actual;
            next_state.velocity_demand = demand_velocity;
            next_state.posmode_loop_error = posmode_error_in;
            next_state.velmode_loop_error = velmode_error_in;
            next_state.target_reached = in_window;
            next_state.zero_speed = below_threshold;
        end
        // Status bits released outside velocity modes
        if (!velocity_mode) begin
            next_state.target_reached = 1'b0;
            next_state.zero_speed = 1'b0;
        end
        // One answer per request, the cycle after it
        if (od_req) begin
            next_state.ack = 1'b1;
            next_state.abort = access_abort != vwm_pkg::ABORT_NONE;
            next_state.abort_code = access_abort;
            next_state.rdata = od_write ? vwm_pkg::RST_VALUE32 : read_value;
            if (access_abort != vwm_pkg::ABORT_NONE) begin
                next_state.rdata = vwm_pkg::RST_VALUE32;
            end
            if (od_write && access_abort == vwm_pkg::ABORT_NONE) begin
                unique case (od_index)
                    vwm_pkg::IDX_VELOCITY_WINDOW: begin
                        next_state.velocity_window = od_wdata[15:0];
                    end
                    vwm_pkg::IDX_VELOCITY_THRESHOLD: begin
                        next_state.velocity_threshold = od_wdata[15:0];
                    end
                    vwm_pkg::IDX_VELOCITY_LOOP_SET: begin
                        unique case (od_subindex)
                            vwm_pkg::SUB_RATE_DIVIDER: begin
                                next_state.loop_rate_divider = od_wdata[15:0];
                            end
                            vwm_pkg::SUB_POSMODE_P_GAIN: begin
                                next_state.posmode_p_gain = od_wdata;
                            end
                            vwm_pkg::SUB_POSMODE_I_GAIN: begin
                                next_state.posmode_i_gain = od_wdata;
                            end
                            vwm_pkg::SUB_VELMODE_P_GAIN: begin
                                next_state.velmode_p_gain = od_wdata;
                            end
                            vwm_pkg::SUB_VELMODE_I_GAIN: begin
                                next_state.velmode_i_gain = od_wdata;
                            end
                            vwm_pkg::SUB_VELMODE_INTEGRAL_ERROR_GAIN: begin
                                next_state.velmode_integral_error_gain = od_wdata;
                            end
                            default: next_state.abort = next_state.abort;
                        endcase
                    end
                    default: next_state.abort = next_state.abort;
                endcase
            end
        end
    end

    // State register; gains come up at their defaults
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register
    assign od_ack = state.ack;
    assign od_abort = state.abort;
    assign od_abort_code = state.abort_code;
    assign od_rdata = state.rdata;
    assign target_reached = state.target_reached;
    assign zero_speed = state.zero_speed;
    assign sensor_velocity = state.sensor_velocity;
    assign velocity_actual = state.velocity_actual;
    assign velocity_demand = state.velocity_demand;
    assign loop_rate_divider = state.loop_rate_divider;
    assign posmode_p_gain = state.posmode_p_gain;
    assign posmode_i_gain = state.posmode_i_gain;
    assign velmode_p_gain = state.velmode_p_gain;
    assign velmode_i_gain = state.velmode_i_gain;
    assign velmode_integral_error_gain = state.velmode_integral_error_gain;
    assign posmode_loop_error = state.posmode_loop_error;
    assign velmode_loop_error = state.velmode_loop_error;

endmodule
`default_nettype wire

// File: common/vwm_pkg.sv
`default_nettype none
package vwm_pkg;

    // Object dictionary indexes of the velocity objects
    localparam logic [15:0] IDX_SENSOR_VELOCITY = 16'h6069;
    localparam logic [15:0] IDX_VELOCITY_DEMAND = 16'h606B;
    localparam logic [15:0] IDX_VELOCITY_ACTUAL = 16'h606C;
    localparam logic [15:0] IDX_VELOCITY_WINDOW = 16'h606D;
    localparam logic [15:0] IDX_VELOCITY_THRESHOLD = 16'h606F;
    localparam logic [15:0] IDX_VELOCITY_LOOP_SET = 16'h60F9;

    // Sub-entries of the velocity loop tuning record
    localparam logic [7:0] SUB_ZERO = 8'h00;
    localparam logic [7:0] SUB_RATE_DIVIDER = 8'h01;
    localparam logic [7:0] SUB_POSMODE_P_GAIN = 8'h02;
    localparam logic [7:0] SUB_POSMODE_I_GAIN = 8'h03;
    localparam logic [7:0] SUB_POSMODE_LOOP_ERROR = 8'h04;
    localparam logic [7:0] SUB_VELMODE_P_GAIN = 8'h05;
    localparam logic [7:0] SUB_VELMODE_I_GAIN = 8'h06;
    localparam logic [7:0] SUB_VELMODE_INTEGRAL_ERROR_GAIN = 8'h07;
    localparam logic [7:0] SUB_VELMODE_LOOP_ERROR = 8'h08;
    localparam logic [7:0] RECORD_ENTRIES = 8'h08;

    // Reset values; gains are IEEE single precision
    localparam logic [31:0] RST_VALUE32 = 32'h0000_0000;
    localparam logic [15:0] RST_VALUE16 = 16'h0000;
    localparam logic [15:0] RST_RATE_DIVIDER = 16'h0001;
    localparam logic [15:0] MIN_RATE_DIVIDER = 16'h0001;
    localparam logic [31:0] RST_P_GAIN = 32'h3D4C_CCCD;
    localparam logic [31:0] RST_I_GAIN = 32'h4000_0000;
    localparam logic [31:0] RST_INTEGRAL_ERROR_GAIN = 32'h0000_0000;
    localparam int FLOAT_SIGN_BIT = 31;

    // Abort answers of the object access port
    localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
    localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h0609_0011;
    localparam logic [31:0] ABORT_VALUE_LOW = 32'h0609_0032;

    // Sample rate and unit scaling
    localparam logic [31:0] SAMPLE_RATE_HZ_DEF = 32'h0000_1F40;
    localparam int SCALE_FRAC_BITS = 16;

endpackage
`default_nettype wire

// File: verilog/vwm_vel_scaler.sv
`timescale 1ns/100ps
`default_nettype none
module vwm_vel_scaler #(
    parameter int FRAC_BITS = vwm_pkg::SCALE_FRAC_BITS
) (
    input wire logic [31:0] sensor_velocity,
    input wire logic [31:0] unit_scale,
    output logic [31:0] scaled_velocity
);

    logic signed [64:0] product;

    // Signed velocity times unsigned fixed point factor
    always_comb begin
        product = $signed({{33{sensor_velocity[31]}}, sensor_velocity})
                  * $signed({33'h0, unit_scale});
        scaled_velocity = product[FRAC_BITS +: 32]; // Drop fraction bits
    end

endmodule
`default_nettype wire

// File: tb/vwm_master.sv
`timescale 1ns/100ps
`default_nettype none
module vwm_master (
    input wire logic core_clk,
    input wire logic od_ack,
    input wire logic [31:0] od_abort_code,
    input wire logic [31:0] od_rdata,
    output logic od_req,
    output logic od_write,
    output logic [15:0] od_index,
    output logic [7:0] od_subindex,
    output logic [31:0] od_wdata
);
    // Idle bus at time zero
    initial begin
        od_req = 1'b0;
        od_write = 1'b0;
        od_index = 16'h0000;
        od_subindex = 8'h00;
        od_wdata = 32'h0000_0000;
    end

    // One object access, request taken on a single edge
    task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, output logic [31:0] r, output logic [31:0] c);
        int n;
        @(posedge core_clk);
        #1;
        od_req = 1'b1;
        od_write = w;
        od_index = i;
        od_subindex = s;
        od_wdata = d;
        @(posedge core_clk);
        #1;
        // Released lines show garbage, not the last value
        od_req = 1'b0;
        od_index = ~i;
        od_subindex = ~s;
        od_wdata = ~d;
        n = 0;
        while (od_ack !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        r = od_rdata;
        c = (od_ack === 1'b1) ? od_abort_code : 32'hFFFF_FFFF;
    endtask
endmodule
`default_nettype wire

// File: tb/vwm_monitor_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module vwm_monitor_checker #(
    parameter logic [31:0] SAMPLE_RATE_HZ = vwm_pkg::SAMPLE_RATE_HZ_DEF
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sample_tick,
    input wire logic velocity_mode,
    input wire logic velocity_polarity,
    input wire logic [31:0] vel_incs_per_sample,
    input wire logic [31:0] demand_velocity,
    input wire logic [31:0] vel_unit_scale,
    input wire logic [31:0] posmode_error_in,
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_subindex,
    input wire logic [31:0] od_wdata,
    input wire logic od_ack,
    input wire logic od_abort,
    input wire logic [31:0] od_abort_code,
    input wire logic target_reached,
    input wire logic zero_speed,
    input wire logic [31:0] sensor_velocity,
    input wire logic [31:0] velocity_actual,
    input wire logic [31:0] velocity_demand,
    input wire logic [15:0] loop_rate_divider,
    input wire logic [31:0] posmode_loop_error
);
    logic [31:0] scale_q;
    logic signed [63:0] prod;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Scale seen one cycle earlier, product of unit conversion
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scale_q <= 32'h0000_0000;
        end else begin
            scale_q <= vel_unit_scale;
        end
    end
    assign prod = $signed(sensor_velocity) * $signed({32'h0000_0000, scale_q});
    sequence tick_s;
        sample_tick;
    endsequence
    sequence wr_s(logic [15:0] i);
        od_req && od_write && od_index == i;
    endsequence
    ack_next_a: assert property (od_req |=> od_ack) else $error("no answer");
    ack_idle_a: assert property (!od_req |=> !od_ack) else $error("stray answer");
    sensor_rate_a: assert property (tick_s |=> sensor_velocity == ($past(velocity_polarity)
        ? -($past(vel_incs_per_sample) * SAMPLE_RATE_HZ)
        : $past(vel_incs_per_sample) * SAMPLE_RATE_HZ)) else $error("sensor value");
    actual_scale_a: assert property (tick_s |=> velocity_actual == prod[47:16])
        else $error("actual value");
    demand_copy_a: assert property (tick_s |=> velocity_demand == $past(demand_velocity))
        else $error("demand value");
    error_copy_a: assert property (tick_s |=> posmode_loop_error == $past(posmode_error_in))
        else $error("loop error");
    mode_gate_a: assert property (!velocity_mode |=> !target_reached && !zero_speed)
        else $error("status outside mode");
    status_moment_a: assert property ($changed(target_reached) || $changed(zero_speed)
        |-> $past(sample_tick) || !$past(velocity_mode)) else $error("status moment");
    ro_actual_a: assert property (wr_s(vwm_pkg::IDX_VELOCITY_ACTUAL) |=> od_abort
        && od_abort_code == vwm_pkg::ABORT_READ_ONLY) else $error("read-only write");
    div_low_a: assert property (wr_s(vwm_pkg::IDX_VELOCITY_LOOP_SET) && od_subindex == 8'h01
        && $signed(od_wdata[15:0]) < 1 |=> od_abort && $stable(loop_rate_divider)
        && od_abort_code == vwm_pkg::ABORT_VALUE_LOW) else $error("divider low");
    div_min_a: assert property ($signed(loop_rate_divider) > 0) else $error("divider");
endmodule
bind vwm_monitor vwm_monitor_checker #(.SAMPLE_RATE_HZ(SAMPLE_RATE_HZ)) i_checker (.core_clk,
    .rstn, .sample_tick, .velocity_mode, .velocity_polarity, .vel_incs_per_sample,
    .demand_velocity, .vel_unit_scale, .posmode_error_in, .od_req, .od_write, .od_index,
    .od_subindex, .od_wdata, .od_ack, .od_abort, .od_abort_code, .target_reached,
    .zero_speed, .sensor_velocity, .velocity_actual, .velocity_demand,
    .loop_rate_divider, .posmode_loop_error);
`default_nettype wire

// File: tb/velocity_window_monitor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module velocity_window_monitor_bench;
    logic core_clk, rstn, sample_tick, velocity_mode, velocity_polarity;
    logic [31:0] vel_incs_per_sample, target_velocity, demand_velocity, vel_unit_scale;
    logic [31:0] posmode_error_in, velmode_error_in, od_wdata, od_abort_code, od_rdata;
    logic od_req, od_write, od_ack, od_abort, target_reached, zero_speed;
    logic [15:0] od_index, loop_rate_divider;
    logic [7:0] od_subindex;
    logic [31:0] sensor_velocity, velocity_actual, velocity_demand, posmode_p_gain;
    logic [31:0] posmode_i_gain, velmode_p_gain, velmode_i_gain, velmode_integral_error_gain;
    logic [31:0] posmode_loop_error, velmode_loop_error;
    logic [31:0] rec_exp [8];
    int mismatches, check_count, cycles;
    // Small sample rate keeps expected products readable
    vwm_monitor #(.SAMPLE_RATE_HZ(32'h0000_000A)) i_dut (.core_clk, .rstn, .sample_tick,
        .velocity_mode, .velocity_polarity, .vel_incs_per_sample, .target_velocity,
        .demand_velocity, .vel_unit_scale, .posmode_error_in, .velmode_error_in, .od_req,
        .od_write, .od_index, .od_subindex, .od_wdata, .od_ack, .od_abort, .od_abort_code,
        .od_rdata, .target_reached, .zero_speed, .sensor_velocity, .velocity_actual,
        .velocity_demand, .loop_rate_divider, .posmode_p_gain, .posmode_i_gain,
        .velmode_p_gain, .velmode_i_gain, .velmode_integral_error_gain,
        .posmode_loop_error, .velmode_loop_error);
    vwm_master i_master (.core_clk, .od_ack, .od_abort_code, .od_rdata, .od_req, .od_write,
        .od_index, .od_subindex, .od_wdata);
    task automatic finish_test();
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
        input logic [31:0] c);
        logic [31:0] r, k;
        i_master.access(1'b1, i, s, d, r, k);
        chk(k, c);
    endtask
    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
        logic [31:0] r, k;
        i_master.access(1'b0, i, s, 32'h0000_0000, r, k);
        chk(k, vwm_pkg::ABORT_NONE);
        chk(r, e);
    endtask
    // One sample period with the given increments
    task automatic tick(input logic [31:0] incs, input logic [31:0] tgt);
        @(posedge core_clk);
        #1;
        vel_incs_per_sample = incs;
        target_velocity = tgt;
        sample_tick = 1'b1;
        @(posedge core_clk);
        #1;
        sample_tick = 1'b0;
    endtask
    // Clock and cycle ceiling
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    // Main sequence
    initial begin
        {rstn, sample_tick, velocity_mode, velocity_polarity} = 4'h0;
        {vel_incs_per_sample, target_velocity, demand_velocity} = 96'h0;
        {posmode_error_in, velmode_error_in} = 64'h0;
        vel_unit_scale = 32'h0001_0000;
        repeat (4) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        rec_exp = '{32'h8, 32'h1, vwm_pkg::RST_P_GAIN, vwm_pkg::RST_I_GAIN, 32'h0,
            vwm_pkg::RST_P_GAIN, vwm_pkg::RST_I_GAIN, 32'h0};
        for (int n = 0; n < 8; n++) rd(16'h60F9, 8'(n), rec_exp[n]);
        chk(posmode_i_gain, vwm_pkg::RST_I_GAIN);
        chk(velmode_p_gain, vwm_pkg::RST_P_GAIN);
        chk(velmode_i_gain, vwm_pkg::RST_I_GAIN);
        chk(velmode_integral_error_gain, vwm_pkg::RST_INTEGRAL_ERROR_GAIN);
        rd(16'h606D, 8'h00, 32'h0);
        rd(16'h606F, 8'h00, 32'h0);
        wr(16'h6069, 8'h00, 32'h1, vwm_pkg::ABORT_READ_ONLY);
        wr(16'h606B, 8'h00, 32'h1, vwm_pkg::ABORT_READ_ONLY);
        wr(16'h606C, 8'h00, 32'h1, vwm_pkg::ABORT_READ_ONLY);
        wr(16'h60F9, 8'h04, 32'h1, vwm_pkg::ABORT_READ_ONLY);
        wr(16'h60F9, 8'h08, 32'h1, vwm_pkg::ABORT_READ_ONLY);
        wr(16'h60F9, 8'h00, 32'h1, vwm_pkg::ABORT_READ_ONLY);
        wr(16'h60F9, 8'h09, 32'h1, vwm_pkg::ABORT_NO_SUBINDEX);
        wr(16'h606D, 8'h01, 32'h1, vwm_pkg::ABORT_NO_SUBINDEX);
        wr(16'h6070, 8'h00, 32'h1, vwm_pkg::ABORT_NO_OBJECT);
        wr(16'h60F9, 8'h01, 32'h0, vwm_pkg::ABORT_VALUE_LOW);
        wr(16'h60F9, 8'h01, 32'hFFFF, vwm_pkg::ABORT_VALUE_LOW);
        rd(16'h60F9, 8'h01, 32'h1);
        wr(16'h60F9, 8'h01, 32'h7FFF, vwm_pkg::ABORT_NONE);
        rd(16'h60F9, 8'h01, 32'h7FFF);
        wr(16'h60F9, 8'h02, 32'hBF80_0000, vwm_pkg::ABORT_VALUE_LOW);
        chk(posmode_p_gain, vwm_pkg::RST_P_GAIN);
        wr(16'h60F9, 8'h07, 32'h3F00_0000, vwm_pkg::ABORT_NONE);
        rd(16'h60F9, 8'h07, 32'h3F00_0000);
        chk(velmode_integral_error_gain, 32'h3F00_0000);
        wr(16'h60F9, 8'h03, 32'h3F80_0000, vwm_pkg::ABORT_NONE);
        chk(posmode_i_gain, 32'h3F80_0000);
        wr(16'h606D, 8'h00, 32'h1234_FFFF, vwm_pkg::ABORT_NONE);
        rd(16'h606D, 8'h00, 32'h0000_FFFF);
        wr(16'h606D, 8'h00, 32'h2, vwm_pkg::ABORT_NONE);
        wr(16'h606F, 8'h00, 32'h1E, vwm_pkg::ABORT_NONE);
        // Velocity mode: window edge, threshold edge, polarity, scale
        velocity_mode = 1'b1;
        demand_velocity = 32'hFFFF_FFF9;
        posmode_error_in = 32'h3F80_0000;
        velmode_error_in = 32'h4040_0000;
        tick(32'h3, 32'h20);
        chk(sensor_velocity, 32'h1E);
        chk(velocity_actual, 32'h1E);
        chk({target_reached, zero_speed}, 32'h3);
        rd(16'h606B, 8'h00, 32'hFFFF_FFF9);
        rd(16'h606C, 8'h00, 32'h1E);
        rd(16'h60F9, 8'h04, 32'h3F80_0000);
        rd(16'h60F9, 8'h08, 32'h4040_0000);
        chk(velmode_loop_error, 32'h4040_0000);
        tick(32'h3, 32'h21);
        chk({target_reached, zero_speed}, 32'h1);
        tick(32'h4, 32'h28);
        chk({target_reached, zero_speed}, 32'h2);
        velocity_polarity = 1'b1;
        tick(32'h3, 32'h28);
        rd(16'h6069, 8'h00, 32'hFFFF_FFE2);
        chk({target_reached, zero_speed}, 32'h1);
        velocity_polarity = 1'b0;
        vel_unit_scale = 32'h0000_8000;
        tick(32'h3, 32'h0F);
        chk(velocity_actual, 32'h0F);
        chk({target_reached, zero_speed}, 32'h3);
        velocity_mode = 1'b0;
        tick(32'h3, 32'h0F);
        chk({target_reached, zero_speed}, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
